//--- verilog/rcexa_map.svh
// Address, field, reset and encoding constants of the execution core
`ifndef RCEXA_MAP_SVH
`define RCEXA_MAP_SVH
`define RCX_A_INDIR 8'h00
`define RCX_A_PC 8'h02
`define RCX_A_ST 8'h03
`define RCX_A_FSR 8'h04
`define RCX_A_PORT 8'h05
`define RCX_ST_C 0
`define RCX_ST_DC 1
`define RCX_ST_Z 2
`define RCX_ST_PG 7:5
`define RCX_ST_KEEP 4:3
`define RCX_ST_RST 8'h18
`define RCX_FSR_RST 8'h80
`define RCX_MODE_RST 8'h1f
`define RCX_CFG_RST 8'hff
`define RCX_PC_RST 12'hfff
`define RCX_MODE_DIR 4'hf
`define RCX_MODE_PLP 4'he
`define RCX_MODE_LVL 4'hd
`define RCX_PRS_BIT 7
`define RCX_NONVOLATILE_CONFIG_WORD_DIV_BIT 11
`define RCX_F_INDIR 5'h00
`define RCX_C_RET 5'h01
`define RCX_C_PROGRAM_WORD_READ_OP 5'h02
`define RCX_C_PCFG 5'h03
`define RCX_C_MODEW 5'h04
`define RCX_C_BANK 2'h1
`define RCX_B_CTRL 4'h0
`define RCX_B_T2B 4'h1
`define RCX_B_W 4'h2
`define RCX_B_ST 4'h3
`define RCX_B_FSR 4'h4
`define RCX_B_PCL 4'h5
`define RCX_B_PCH 4'h6
`define RCX_B_MODE 4'h7
`endif

//--- verilog/rcexa_pkg.sv
// Types of the execution core
package rcexa_pkg;
	typedef enum logic [1:0] {G_BYTE = 2'b00, G_BIT = 2'b01, G_BR = 2'b10, G_LIT = 2'b11} rcexa_grp_t;
	typedef enum logic [3:0] {
		BO_CTL = 4'h0, BO_CLR = 4'h1, BO_SUB = 4'h2, BO_DEC = 4'h3,
		BO_OR = 4'h4, BO_AND = 4'h5, BO_XOR = 4'h6, BO_ADD = 4'h7,
		BO_MOV = 4'h8, BO_NOT = 4'h9, BO_DSZ = 4'ha, BO_ISZ = 4'hb,
		BO_INC = 4'hc, BO_RR = 4'hd, BO_RL = 4'he, BO_SWAP = 4'hf
	} rcexa_bop_t;
	typedef enum logic {FS_RUN = 1'b0, FS_IRD = 1'b1} rcexa_fst_t;
endpackage

//--- verilog/rcexa_core.sv
// Pipelined 8-bit execution core with data addressing, stack and port
// Summary of operation
// RULE1 - three instruction families: byte, bit, literal/control
// RULE2 - each instruction is one 12-bit word
// RULE3 - one cycle; branches and taken skips two; here a PC write takes three and a program read four
// RULE4 - fetch, decode, execute, write-back, one clock each
// RULE5 - one instruction retires per clock when full
// RULE6 - PC changes flush younger pipeline entries
// RULE7 - core runs only with nonvolatile_config_word bit 11 clear
// RULE8 - accumulator: second operand, literal sink, destination
// RULE9 - file register first operand; destination bit selects
// RULE10 - status word is a readable, writable register
// RULE11 - status bits C, DC, Z, PD, TO, page
// RULE12 - writing PC low byte redirects execution
// RULE13 - PC at 02h, status 03h, pointer 04h
// RULE14 - program read at mode upper nibble and accumulator
// RULE15 - eight-entry 12-bit return stack, call/return
// RULE16 - push drops deepest; pop duplicates deepest
// RULE17 - indirect slot acts on pointer-addressed register
// RULE18 - bank op loads pointer bits 6:4 only
// RULE19 - pointer bit 7 picks bank group
// RULE20 - semidirect address joins pointer bank and field
// RULE21 - bit ops reach any data memory bit
// RULE22 - port has direction, threshold, pull-up registers
// RULE23 - mode selects port register; move loads it
// RULE24 - software spaces port read-modify-writes with no-ops
// RULE25 - default port read returns pin levels
// RULE26 - read-source bit selects data register instead
// RULE27 - increment/decrement, write back, skip on zero
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rcexa_map.svh"
module rcexa_core
	import rcexa_pkg::*;
(
	input wire logic clock, // 10 MHz core clock
	input wire logic rst_n, // Synchronous reset, active low
	output logic [11:0] prog_addr, // Program memory address
	input wire logic [11:0] prog_data, // Word of last cycle's address
	input wire logic [11:0] nonvolatile_config_word_word, // Configuration nonvolatile_config_word word
	input wire logic [7:0] pin_in, // Port pin levels
	output logic [7:0] port_out, // Port data register
	output logic [7:0] port_oe, // Port drive enables
	output logic [7:0] port_cmos, // Port threshold select
	output logic [7:0] port_pullup_n, // Pull-up enables, low active
	output logic retire, // Instruction retired pulse
	input wire logic [3:0] bus_addr, // Register bus address
	input wire logic [7:0] bus_wdata, // Register bus write data
	input wire logic bus_wr, // Register bus write strobe
	input wire logic bus_rd, // Register bus read strobe
	output logic [7:0] bus_rdata // Register bus read data
);
	logic [7:0] ram [0:255];
	logic [11:0] stk [0:7];
	logic [11:0] next_stk [0:7];
	logic [11:0] fd_pc, ex_pc, ex_ir, ird_ret, next_prog_addr, next_fd_pc, next_ex_pc, next_ex_ir, next_ird_ret;
	logic fd_valid, ex_valid, next_fd_valid, next_ex_valid, next_retire, halt_nonvolatile_config_word;
	logic wb_en, wb_w_en, wb_st_en, next_wb_en, next_wb_w_en, next_wb_st_en;
	logic [7:0] wb_addr, wb_data, wb_w, wb_st, next_wb_addr, next_wb_data, next_wb_w, next_wb_st;
	logic [7:0] w, status, file_select_pointer, mode, next_w, next_status, next_fsr, next_mode;
	logic [7:0] next_port_out, next_port_oe, next_port_cmos, next_port_pullup_n;
	rcexa_fst_t fst, next_fst;
	logic ird_load, next_ird_load;
	logic run, next_run;
	logic [7:0] t2b, next_t2b, next_bus_rdata;
	logic [7:0] w_f, st_f, fsr_f, port_f, ea, wa, opnd, res, st_n, bmask;
	logic [11:0] ex_pc1, ex_tgt, dec_tgt;
	logic [9:0] sum;
	logic [2:0] pg;
	logic running, we_f, we_w, upd_z, upd_c, skip, ex_redir, dec_redir, push, pop, is_bank;

	// Effective data address: indirect, global or banked field
	function automatic logic [7:0] rcexa_ea(input logic [4:0] f, input logic [7:0] p);
		if (f == `RCX_F_INDIR)
		begin
			rcexa_ea = p; // RULE17
		end
		else if (f[4])
		begin
			rcexa_ea = {p[7:4], f[3:0]}; // RULE20
		end
		else
		begin
			rcexa_ea = {4'h0, f[3:0]};
		end
	endfunction

	// Adder returning carry, digit carry and sum
	function automatic logic [9:0] rcexa_add(input logic [7:0] a, input logic [7:0] b, input logic ci);
		logic [4:0] lo;
		logic [8:0] s;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		rcexa_add = {s[8], lo[4], s[7:0]};
	endfunction

	// Pipeline, execute and write-back next state
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			next_stk[i] = stk[i];
		end
		running = run && !halt_nonvolatile_config_word; // RULE7
		w_f = wb_w_en ? wb_w : w;
		st_f = wb_st_en ? wb_st : status;
		fsr_f = (wb_en && wb_addr == `RCX_A_FSR) ? wb_data : file_select_pointer;
		port_f = (wb_en && wb_addr == `RCX_A_PORT) ? wb_data : port_out;
		ex_pc1 = ex_pc + 12'h001;
		ea = rcexa_ea(ex_ir[4:0], fsr_f); // RULE19
		case (ea)
			`RCX_A_INDIR: opnd = 8'h00;
			`RCX_A_PC: opnd = ex_pc1[7:0]; // RULE13
			`RCX_A_ST: opnd = st_f; // RULE10
			`RCX_A_FSR: opnd = fsr_f;
			`RCX_A_PORT: opnd = t2b[`RCX_PRS_BIT] ? port_f : pin_in; // RULE25 RULE26
			default: opnd = (wb_en && wb_addr == ea) ? wb_data : ram[ea];
		endcase
		bmask = 8'h01 << ex_ir[7:5];
		wa = ea;
		res = 8'h00;
		sum = 10'h000;
		we_f = 1'b0;
		we_w = 1'b0;
		upd_z = 1'b0;
		upd_c = 1'b0;
		skip = 1'b0;
		is_bank = 1'b0;
		ex_redir = 1'b0;
		ex_tgt = ex_pc1;
		st_n = st_f;
		next_fst = FS_RUN;
		next_ird_ret = ird_ret;
		next_mode = mode;
		next_port_oe = port_oe;
		next_port_cmos = port_cmos;
		next_port_pullup_n = port_pullup_n;
		// Execute stage
		if (ex_valid)
		begin
			case (rcexa_grp_t'(ex_ir[11:10])) // RULE1
				G_BYTE:
				begin
					we_f = ex_ir[5]; // RULE9
					we_w = !ex_ir[5]; // RULE8
					upd_z = 1'b1;
					case (rcexa_bop_t'(ex_ir[9:6]))
						BO_CTL:
						begin
							we_w = 1'b0;
							upd_z = 1'b0;
							res = w_f;
							if (!ex_ir[5])
							begin
								if (ex_ir[4:3] == `RCX_C_BANK)
								begin
									is_bank = 1'b1;
									we_f = 1'b1;
									wa = `RCX_A_FSR;
									res = {fsr_f[7], ex_ir[2:0], fsr_f[3:0]}; // RULE18
								end
								else if (ex_ir[4:0] == `RCX_C_PROGRAM_WORD_READ_OP)
								begin
									ex_redir = 1'b1;
									ex_tgt = {mode[7:4], w_f}; // RULE14
									next_fst = FS_IRD;
									next_ird_ret = ex_pc1;
								end
								else if (ex_ir[4:0] == `RCX_C_MODEW)
								begin
									next_mode = w_f;
								end
								else if (ex_ir[4:0] == `RCX_C_PCFG)
								begin
									case (mode[3:0]) // RULE22 RULE23
										`RCX_MODE_DIR: next_port_oe = ~w_f;
										`RCX_MODE_LVL: next_port_cmos = w_f;
										`RCX_MODE_PLP: next_port_pullup_n = w_f;
										default: next_port_oe = port_oe;
									endcase
								end
							end
						end
						BO_CLR: res = 8'h00;
						BO_SUB:
						begin
							sum = rcexa_add(opnd, ~w_f, 1'b1);
							upd_c = 1'b1;
						end
						BO_DEC: sum = rcexa_add(opnd, 8'hff, 1'b0);
						BO_OR: res = opnd | w_f;
						BO_AND: res = opnd & w_f;
						BO_XOR: res = opnd ^ w_f;
						BO_ADD:
						begin
							sum = rcexa_add(opnd, w_f, 1'b0);
							upd_c = 1'b1;
						end
						BO_MOV: res = opnd;
						BO_NOT: res = ~opnd;
						BO_DSZ, BO_ISZ:
						begin
							sum = rcexa_add(opnd, ex_ir[6] ? 8'h01 : 8'hff, 1'b0);
							upd_z = 1'b0;
							skip = sum[7:0] == 8'h00; // RULE27
						end
						BO_INC: sum = rcexa_add(opnd, 8'h01, 1'b0);
						BO_RR:
						begin
							res = {st_f[`RCX_ST_C], opnd[7:1]};
							upd_z = 1'b0;
							st_n[`RCX_ST_C] = opnd[0];
						end
						BO_RL:
						begin
							res = {opnd[6:0], st_f[`RCX_ST_C]};
							upd_z = 1'b0;
							st_n[`RCX_ST_C] = opnd[7];
						end
						default:
						begin
							res = {opnd[3:0], opnd[7:4]};
							upd_z = 1'b0;
						end
					endcase
					if (ex_ir[9:6] == BO_SUB || ex_ir[9:6] == BO_DEC || ex_ir[9:6] == BO_ADD ||
						ex_ir[9:6] == BO_DSZ || ex_ir[9:6] == BO_ISZ || ex_ir[9:6] == BO_INC)
					begin
						res = sum[7:0];
					end
				end
				G_BIT:
				begin
					case (ex_ir[9:8]) // RULE21
						2'b00: res = opnd & ~bmask;
						2'b01: res = opnd | bmask;
						2'b10: skip = (opnd & bmask) == 8'h00;
						default: skip = (opnd & bmask) != 8'h00;
					endcase
					we_f = !ex_ir[9];
				end
				G_BR:
				begin
					res = ex_ir[7:0];
					we_w = ex_ir[9:8] == 2'b01;
				end
				default:
				begin
					we_w = 1'b1; // RULE8
					upd_z = ex_ir[9:8] != 2'b00;
					case (ex_ir[9:8])
						2'b00: res = ex_ir[7:0];
						2'b01: res = w_f | ex_ir[7:0];
						2'b10: res = w_f & ex_ir[7:0];
						default: res = w_f ^ ex_ir[7:0];
					endcase
				end
			endcase
		end
		// Flags, then a status or PC destination
		if (upd_z)
		begin
			st_n[`RCX_ST_Z] = res == 8'h00;
		end
		if (upd_c)
		begin
			st_n[`RCX_ST_C] = sum[9];
			st_n[`RCX_ST_DC] = sum[8];
		end
		next_wb_st_en = ex_valid && st_n != st_f;
		next_wb_en = 1'b0;
		if (we_f)
		begin
			if (wa == `RCX_A_PC)
			begin
				ex_redir = 1'b1;
				ex_tgt = {ex_pc[11:9], 1'b0, res}; // RULE12
			end
			else if (wa == `RCX_A_ST)
			begin
				st_n = {res[`RCX_ST_PG], st_f[`RCX_ST_KEEP], res[2:0]}; // RULE10 RULE11
				next_wb_st_en = 1'b1;
			end
			else
			begin
				next_wb_en = wa != `RCX_A_INDIR; // RULE17
			end
		end
		next_wb_addr = wa;
		next_wb_data = res;
		next_wb_w_en = we_w;
		next_wb_w = res;
		next_wb_st = st_n;
		next_retire = ex_valid; // RULE5
		// Decode stage branches, call and return
		pg = st_n[`RCX_ST_PG];
		push = 1'b0;
		pop = 1'b0;
		dec_tgt = stk[0];
		dec_redir = fd_valid && !skip && !ex_redir &&
			(prog_data[11:10] == G_BR || prog_data[11:0] == {7'h00, `RCX_C_RET});
		if (dec_redir)
		begin
			if (prog_data[9])
			begin
				dec_tgt = {pg, prog_data[8:0]};
			end
			else if (prog_data[11:8] == 4'h8)
			begin
				push = 1'b1;
				dec_tgt = {pg, 1'b0, prog_data[7:0]};
			end
			else
			begin
				pop = 1'b1;
			end
		end
		if (push)
		begin
			next_stk[0] = fd_pc + 12'h001; // RULE15
			for (int i = 1; i < 8; i++)
			begin
				next_stk[i] = stk[i - 1]; // RULE16
			end
		end
		if (pop)
		begin
			for (int i = 0; i < 7; i++)
			begin
				next_stk[i] = stk[i + 1]; // RULE16
			end
		end
		// Write-back stage
		next_w = wb_w_en ? wb_w : w;
		next_status = wb_st_en ? wb_st : status;
		next_fsr = fsr_f;
		next_port_out = port_f;
		// Fetch and stage advance
		next_ex_ir = prog_data; // RULE2
		next_ex_pc = fd_pc;
		next_ex_valid = fd_valid && !skip && !ex_redir; // RULE3
		next_fd_pc = prog_addr;
		next_fd_valid = 1'b0;
		next_prog_addr = prog_addr;
		// Program read word arrives one cycle after its address
		next_ird_load = fst == FS_IRD;
		if (ird_load)
		begin
			next_w = prog_data[7:0]; // RULE14
			next_mode = {prog_data[11:8], mode[3:0]};
		end
		if (fst == FS_IRD)
		begin
			next_prog_addr = ird_ret;
		end
		else if (ex_redir)
		begin
			next_prog_addr = ex_tgt; // RULE6
		end
		else if (dec_redir)
		begin
			next_prog_addr = dec_tgt; // RULE6
		end
		else if (running)
		begin
			next_prog_addr = prog_addr + 12'h001; // RULE4
			next_fd_valid = 1'b1;
		end
	end

	// Core registers
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			prog_addr <= `RCX_PC_RST;
			fd_pc <= `RCX_PC_RST;
			ex_pc <= `RCX_PC_RST;
			ex_ir <= 12'h000;
			ird_ret <= `RCX_PC_RST;
			fd_valid <= 1'b0;
			ex_valid <= 1'b0;
			retire <= 1'b0;
			halt_nonvolatile_config_word <= 1'b1;
			wb_en <= 1'b0;
			wb_w_en <= 1'b0;
			wb_st_en <= 1'b0;
			wb_addr <= 8'h00;
			wb_data <= 8'h00;
			wb_w <= 8'h00;
			wb_st <= `RCX_ST_RST;
			w <= 8'h00;
			status <= `RCX_ST_RST;
			file_select_pointer <= `RCX_FSR_RST;
			mode <= `RCX_MODE_RST;
			port_out <= 8'h00;
			port_oe <= ~`RCX_CFG_RST;
			port_cmos <= `RCX_CFG_RST;
			port_pullup_n <= `RCX_CFG_RST;
			fst <= FS_RUN;
			ird_load <= 1'b0;
			for (int i = 0; i < 8; i++)
			begin
				stk[i] <= 12'h000;
			end
		end
		else
		begin
			prog_addr <= next_prog_addr;
			fd_pc <= next_fd_pc;
			ex_pc <= next_ex_pc;
			ex_ir <= next_ex_ir;
			ird_ret <= next_ird_ret;
			fd_valid <= next_fd_valid;
			ex_valid <= next_ex_valid;
			retire <= next_retire;
			halt_nonvolatile_config_word <= nonvolatile_config_word_word[`RCX_NONVOLATILE_CONFIG_WORD_DIV_BIT];
			wb_en <= next_wb_en;
			wb_w_en <= next_wb_w_en;
			wb_st_en <= next_wb_st_en;
			wb_addr <= next_wb_addr;
			wb_data <= next_wb_data;
			wb_w <= next_wb_w;
			wb_st <= next_wb_st;
			w <= next_w;
			status <= next_status;
			file_select_pointer <= next_fsr;
			mode <= next_mode;
			port_out <= next_port_out;
			port_oe <= next_port_oe;
			port_cmos <= next_port_cmos;
			port_pullup_n <= next_port_pullup_n;
			fst <= next_fst;
			ird_load <= next_ird_load;
			stk <= next_stk;
		end
	end

	// Data memory, written from the write-back stage
	always_ff @(posedge clock)
	begin
		if (wb_en && wb_addr > `RCX_A_PORT)
		begin
			ram[wb_addr] <= wb_data;
		end
	end

	// Register bus next state
	always_comb
	begin
		next_run = run;
		next_t2b = t2b;
		next_bus_rdata = 8'h00;
		if (bus_wr && bus_addr == `RCX_B_CTRL)
		begin
			next_run = bus_wdata[0];
		end
		if (bus_wr && bus_addr == `RCX_B_T2B)
		begin
			next_t2b = bus_wdata; // RULE26
		end
		if (bus_rd)
		begin
			case (bus_addr)
				`RCX_B_CTRL: next_bus_rdata = {6'h00, halt_nonvolatile_config_word, run};
				`RCX_B_T2B: next_bus_rdata = t2b;
				`RCX_B_W: next_bus_rdata = w;
				`RCX_B_ST: next_bus_rdata = status;
				`RCX_B_FSR: next_bus_rdata = file_select_pointer;
				`RCX_B_PCL: next_bus_rdata = prog_addr[7:0];
				`RCX_B_PCH: next_bus_rdata = {4'h0, prog_addr[11:8]};
				`RCX_B_MODE: next_bus_rdata = mode;
				default: next_bus_rdata = 8'h00;
			endcase
		end
	end

	// Register bus registers
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			run <= 1'b1;
			t2b <= 8'h00;
			bus_rdata <= 8'h00;
		end
		else
		begin
			run <= next_run;
			t2b <= next_t2b;
			bus_rdata <= next_bus_rdata;
		end
	end

	// Checks on pipeline, stack, addressing and port reads
	AST_SKIP: assert property (@(posedge clock) disable iff (!rst_n) skip |=> !ex_valid) // RULE27
		else $error("skip kept next instruction");
	AST_FETCH: assert property (@(posedge clock) disable iff (!rst_n) // RULE5
		(running && fst == FS_RUN && !ex_redir && !dec_redir) |=> fd_valid && prog_addr == $past(prog_addr) + 12'h001)
		else $error("fetch did not advance");
	AST_DREDIR: assert property (@(posedge clock) disable iff (!rst_n) // RULE3
		dec_redir |=> (prog_addr == $past(dec_tgt) && !fd_valid) ##1 !ex_valid)
		else $error("branch bubble wrong");
	AST_EXREDIR: assert property (@(posedge clock) disable iff (!rst_n) ex_redir |=> !fd_valid && !ex_valid) // RULE6
		else $error("flush missed");
	AST_PUSH: assert property (@(posedge clock) disable iff (!rst_n) // RULE15
		push |=> stk[0] == $past(fd_pc) + 12'h001 && stk[7] == $past(stk[6]))
		else $error("push wrong");
	AST_POP: assert property (@(posedge clock) disable iff (!rst_n) // RULE16
		pop |=> stk[6] == $past(stk[7]) && stk[7] == $past(stk[7]))
		else $error("pop wrong");
	AST_BANK: assert property (@(posedge clock) disable iff (!rst_n) // RULE18
		(ex_valid && is_bank) |-> ##2 file_select_pointer[6:4] == $past(ex_ir[2:0], 2) && file_select_pointer[3:0] == $past(fsr_f[3:0], 2))
		else $error("bank load wrong");
	AST_INDIR: assert property (@(posedge clock) disable iff (!rst_n) // RULE17
		(ex_ir[4:0] == `RCX_F_INDIR) |-> ea == fsr_f)
		else $error("indirect address wrong");
	AST_PRS: assert property (@(posedge clock) disable iff (!rst_n) // RULE25
		(ea == `RCX_A_PORT && !t2b[`RCX_PRS_BIT]) |-> opnd == pin_in)
		else $error("port read source wrong");
	AST_PROGRAM_WORD_READ_OP: assert property (@(posedge clock) disable iff (!rst_n) // RULE14
		ird_load |=> w == $past(prog_data[7:0]) && mode[7:4] == $past(prog_data[11:8]))
		else $error("program read result wrong");
endmodule
`default_nettype wire

//--- verif/rcexa_core_test.sv
// Self-checking bench of the pipelined execution core
`timescale 1ns/1ps
`default_nettype none
module rcexa_core_test
	import rcexa_pkg::*;
;
	// One program case: words at 000..007, port setup, expected {W,status,fsr,mode} and {oe,cmos,pullup_n}
	typedef struct packed {
		logic [0:7][11:0] prog;
		logic [7:0] t2b;
		logic ovr;
		logic [7:0] ext;
		logic [31:0] regs;
		logic [23:0] pads;
	} rcexa_row_t;

	logic clock;
	logic rst_n;
	logic [11:0] prog_addr;
	logic [11:0] prog_data;
	logic [11:0] nonvolatile_config_word_word;
	logic [7:0] pin_in;
	logic [7:0] port_out;
	logic [7:0] port_oe;
	logic [7:0] port_cmos;
	logic [7:0] port_pullup_n;
	logic retire;
	logic [3:0] bus_addr;
	logic [7:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [7:0] bus_rdata;
	logic [11:0] rom [4096];
	logic ovr;
	logic [7:0] ext;
	int n_fail;
	int compares;
	int n_ret = 0;
	logic [3:0] rst_a [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h9};
	logic [7:0] rst_v [7] = '{8'h01, 8'h00, 8'h00, 8'h18, 8'h80, 8'h1f, 8'h00};

	// Status 00 in a row means status is not compared
	rcexa_row_t rows [22] = '{
		'{{12'hc5c, 12'hfff, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'ha318801f, 24'h00ffff},
		'{{12'hc0f, 12'hd30, 12'he3c, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h3c00801f, 24'h00ffff},
		'{{12'hc07, 12'h028, 12'h1c8, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h0e18801f, 24'h00ffff},
		'{{12'hc07, 12'h028, 12'h1e8, 12'h208, 12'h000, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h0e00801f, 24'h00ffff},
		'{{12'hc0a, 12'h024, 12'hc33, 12'h020, 12'hc00, 12'h20a, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h33000a1f, 24'h00ffff},
		'{{12'h00d, 12'hc44, 12'h03f, 12'h00e, 12'hc55, 12'h03f, 12'h00d, 12'h21f}, 8'h00, 1'b0, 8'h00, 32'h4400d01f, 24'h00ffff},
		'{{12'hc00, 12'h028, 12'h568, 12'h5e8, 12'h468, 12'h208, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h8000801f, 24'h00ffff},
		'{{12'hc01, 12'h028, 12'h2a8, 12'hc11, 12'hd20, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h2100801f, 24'h00ffff},
		'{{12'hc02, 12'h028, 12'h2a8, 12'hc11, 12'hd20, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h3100801f, 24'h00ffff},
		'{{12'hcff, 12'h028, 12'h2e8, 12'hc11, 12'hd40, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'hff00801f, 24'h00ffff},
		'{{12'hc80, 12'h028, 12'h7e8, 12'hc11, 12'hd02, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h8200801f, 24'h00ffff},
		'{{12'hc80, 12'h028, 12'h6e8, 12'hc11, 12'hd02, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h1300801f, 24'h00ffff},
		'{{12'h804, 12'hd40, 12'ha02, 12'h000, 12'hc03, 12'h001, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h4300801f, 24'h00ffff},
		'{{12'h804, 12'hd40, 12'ha02, 12'h000, 12'h905, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h4500801f, 24'h00ffff},
		'{{12'ha03, 12'hc77, 12'hc77, 12'hd08, 12'h000, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h0800801f, 24'h00ffff},
		'{{12'hc04, 12'h022, 12'hc77, 12'hc77, 12'hd01, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'h0500801f, 24'h00ffff},
		'{{12'hc00, 12'h004, 12'hc07, 12'h002, 12'ha04, 12'h000, 12'h000, 12'h5a7}, 8'h00, 1'b0, 8'h00, 32'ha7008050, 24'h00ffff},
		'{{12'hca5, 12'h023, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'h00, 32'ha5bd801f, 24'h00ffff},
		'{{12'hc0e, 12'h004, 12'hcf0, 12'h003, 12'hc0d, 12'h004, 12'hc69, 12'h003}, 8'h00, 1'b0, 8'h00, 32'h6900800d, 24'h0069f0},
		'{{12'hc0e, 12'h004, 12'hcf0, 12'h003, 12'h205, 12'h000, 12'h000, 12'h000}, 8'h00, 1'b0, 8'ha0, 32'haf00800e, 24'h00fff0},
		'{{12'hc0f, 12'h004, 12'hc00, 12'h003, 12'hc5a, 12'h025, 12'h205, 12'h000}, 8'h00, 1'b1, 8'h3c, 32'h3c00800f, 24'hffffff},
		'{{12'hc0f, 12'h004, 12'hc00, 12'h003, 12'hc5a, 12'h025, 12'h205, 12'h000}, 8'h80, 1'b1, 8'h3c, 32'h5a00800f, 24'hffffff}
	};

	rcexa_core i_rcexa_core (
		.clock(clock),
		.rst_n(rst_n),
		.prog_addr(prog_addr),
		.prog_data(prog_data),
		.nonvolatile_config_word_word(nonvolatile_config_word_word),
		.pin_in(pin_in),
		.port_out(port_out),
		.port_oe(port_oe),
		.port_cmos(port_cmos),
		.port_pullup_n(port_pullup_n),
		.retire(retire),
		.bus_addr(bus_addr),
		.bus_wdata(bus_wdata),
		.bus_wr(bus_wr),
		.bus_rd(bus_rd),
		.bus_rdata(bus_rdata)
	);

	// Pin level: driven bits, pull-ups, else outside source; override forces outside source
	assign pin_in = ovr ? ext : ((port_oe & port_out) | (~port_oe & ~port_pullup_n) | (~port_oe & port_pullup_n & ext));

	// Clock generator, 100 ns period
	always #50 clock = ~clock;

	// Synchronous program memory, word in the cycle after the address
	always @(posedge clock)
		prog_data <= rom[prog_addr];

	// Count retired instructions
	always @(posedge clock)
		if (retire === 1'b1)
			n_ret <= n_ret + 1;

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task stop_test;
		$display("Comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task bus_w(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge clock);
		bus_wr <= 1'b0;
	endtask

	task bus_r(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge clock);
		bus_rd <= 1'b0;
		#1 d = bus_rdata;
	endtask

	task do_reset(input int n);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (n) @(posedge clock);
		rst_n <= 1'b1;
	endtask

	// Measure retires and fetch progress over 20 clocks
	task rate(input int exp_ret, input logic chk_pc);
		logic [11:0] a;
		int n0;
		repeat (8) @(posedge clock);
		#1 a = prog_addr;
		n0 = n_ret;
		repeat (20) @(posedge clock);
		#1 check("retires", n_ret - n0, exp_ret);
		if (chk_pc)
			check("fetch address", prog_addr, 12'(a + 12'd20));
	endtask

	// Main sequence
	initial
	begin
		rcexa_row_t r;
		logic [7:0] d;
		clock = 1'b0;
		rst_n = 1'b0;
		nonvolatile_config_word_word = 12'h000;
		bus_addr = 4'h0;
		bus_wdata = 8'h00;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		ovr = 1'b0;
		ext = 8'h00;
		n_fail = 0;
		compares = 0;
		foreach (rom[j])
			rom[j] = 12'h000;
		repeat (11) @(posedge clock);
		#1 check("reset fetch address", prog_addr, 12'hfff);
		check("reset port config", {port_oe, port_cmos, port_pullup_n}, 24'h00ffff);
		@(posedge clock);
		rst_n <= 1'b1;
		foreach (rst_a[k])
		begin
			bus_r(rst_a[k], d);
			check($sformatf("reset reg %0h", rst_a[k]), d, rst_v[k]);
		end
		foreach (rows[i])
		begin
			r = rows[i];
			foreach (rom[j])
				rom[j] = (j < 8) ? r.prog[j] : 12'h000;
			do_reset(2);
			ovr <= r.ovr;
			ext <= r.ext;
			bus_w(4'h1, r.t2b);
			repeat (30) @(posedge clock);
			bus_r(4'h2, d);
			check($sformatf("w row %0d", i), d, r.regs[31:24]);
			bus_r(4'h3, d);
			if (r.regs[23:16] != 8'h00)
				check($sformatf("status row %0d", i), d, r.regs[23:16]);
			bus_r(4'h4, d);
			check($sformatf("pointer row %0d", i), d, r.regs[15:8]);
			bus_r(4'h7, d);
			check($sformatf("mode row %0d", i), d, r.regs[7:0]);
			check($sformatf("port config row %0d", i), {port_oe, port_cmos, port_pullup_n}, r.pads);
		end
		check("port data", port_out, 8'h5a);
		// Straight-line code retires one per clock
		foreach (rom[j])
			rom[j] = 12'h000;
		do_reset(2);
		rate(20, 1'b1);
		// Jump to itself costs two clocks each
		rom[0] = 12'ha00;
		do_reset(2);
		rate(10, 1'b0);
		// Nonvolatile_config_word bit 11 set keeps the core from fetching
		rom[0] = 12'hc05;
		do_reset(2);
		nonvolatile_config_word_word <= 12'h800;
		repeat (20) @(posedge clock);
		#1 check("halted fetch address", prog_addr, 12'hfff);
		bus_r(4'h0, d);
		check("halted control", d, 8'h03);
		bus_r(4'h2, d);
		check("halted w", d, 8'h00);
		bus_r(4'h5, d);
		check("halted pc low", d, 8'hff);
		bus_r(4'h6, d);
		check("halted pc high", d, 8'h0f);
		// Clearing the run bit freezes fetch at the first address
		do_reset(2);
		nonvolatile_config_word_word <= 12'h000;
		bus_w(4'h0, 8'h00);
		repeat (20) @(posedge clock);
		#1 check("stopped fetch address", prog_addr, 12'h000);
		bus_r(4'h0, d);
		check("stopped control", d, 8'h00);
		stop_test;
	end

	// Watchdog against a hang
	initial
	begin
		repeat (6000) @(posedge clock);
		n_fail++;
		$display("ERROR watchdog expected finish seen hang");
		stop_test;
	end
endmodule
`default_nettype wire
